// ---- ddrg_defines.svh ----
`ifndef DDRG_DEFINES_SVH
`define DDRG_DEFINES_SVH

////////////////////////////////////////////////////////////////
// Address geometry
`define DDRG_COL_W        10
`define DDRG_BA_W         2
`define DDRG_BG_W_WIDE    2
`define DDRG_BG_W_X16     1
`define DDRG_ROW_W_X4     17
`define DDRG_ROW_W_X8     16
`define DDRG_BANKS_WIDE   16
`define DDRG_BANKS_X16    8
`define DDRG_AP_BIT       10

////////////////////////////////////////////////////////////////
// Burst shape
`define DDRG_BURST_LEN    8
`define DDRG_BURST_CLK    4

////////////////////////////////////////////////////////////////
// Command codes, {act_n, ras_n, cas_n, we_n}
`define DDRG_CMD_NOP      4'hF
`define DDRG_CMD_ACT      4'h7
`define DDRG_CMD_RD       4'hD
`define DDRG_CMD_WR       4'hC
`define DDRG_CMD_PRE      4'hA
`define DDRG_CMD_REF      4'h9

////////////////////////////////////////////////////////////////
// Timing
`define DDRG_CLK_PS       4000
`define DDRG_TREFI_PS     7812500
`define DDRG_TREFI_HOT_PS 3906250
`define DDRG_TREFI_CYC    (`DDRG_TREFI_PS / `DDRG_CLK_PS)
`define DDRG_TREFI_HOT_CYC (`DDRG_TREFI_HOT_PS / `DDRG_CLK_PS)
`define DDRG_REF_PER_WIN  8192
`define DDRG_REF_PEND_MAX 4'hF
`define DDRG_TRFC_CYC     64
`define DDRG_CL_RESET     5'h16

`endif

// ---- ddrg_pkg.sv ----
package ddrg_pkg;

	typedef enum logic [2:0] {
		DDRG_R1600 = 3'h0,
		DDRG_R1866 = 3'h1,
		DDRG_R2133 = 3'h2,
		DDRG_R2400 = 3'h3,
		DDRG_R2666 = 3'h4,
		DDRG_R2933 = 3'h5,
		DDRG_R3200 = 3'h6
	} ddrg_rate_t;

	typedef enum logic [9:0] {
		DDRG_H_IDLE  = 10'h001,
		DDRG_H_NOP   = 10'h002,
		DDRG_H_REF   = 10'h004,
		DDRG_H_ACT   = 10'h008,
		DDRG_H_RCD   = 10'h010,
		DDRG_H_COL   = 10'h020,
		DDRG_H_LAT   = 10'h040,
		DDRG_H_BURST = 10'h080,
		DDRG_H_PRE   = 10'h100,
		DDRG_H_RP    = 10'h200
	} ddrg_hst_t;

	typedef enum logic [2:0] {
		DDRG_D_IDLE  = 3'h1,
		DDRG_D_LAT   = 3'h2,
		DDRG_D_BURST = 3'h4
	} ddrg_dst_t;

endpackage

// ---- ddrg_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface ddrg_link_if #(parameter int ORG = 8);
	logic               cs_n;
	logic               act_n;
	logic               ras_n;
	logic               cas_n;
	logic               we_n;
	logic [1:0]         bg;
	logic [1:0]         ba;
	logic [16:0]        addr;
	logic [2*ORG-1:0]   h_dq_o;
	logic               h_dq_oe;
	logic [2*ORG-1:0]   d_dq_o;
	logic               d_dq_oe;
	logic [2*ORG-1:0]   dq;

	// Shared data wire, low half is the rising-edge word
	assign dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : '0);

	modport host (
		output cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, h_dq_o, h_dq_oe,
		input  dq
	);
	modport dev (
		input  cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, dq,
		output d_dq_o, d_dq_oe
	);
endinterface

`default_nettype wire

// ---- ddrg_host.sv ----
// Operation
// [R1] x4/x8: sixteen banks, four groups
// [R2] x16: eight banks, two groups
// [R3] Row 17 bits x4, 16 otherwise
// [R4] Column always ten low address bits
// [R5] Page equals columns times width over eight; x4 with X4_PAGE1K set reports 1024
// [R6] One access is four clock burst
// [R7] Two data words every clock
// [R8] 8192 refreshes per 64 ms, cool
// [R9] Hot case: 8192 per 32 ms
// [R10] Hot case selects hot self refresh
// [R11] CL, row delay, precharge equal
// [R12] Top grade runs slower listed latencies
// [R13] Idle slots deselect; NOP rarely
// [R14] Never rely on undefined behaviour
// [R15] Timing assumes DLL enabled
// [R16] Average refresh spacing 7.8125/3.90625 us
// [R17] Split flat address per width
`include "ddrg_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ddrg_host #(
	parameter int ORG      = 8,
	parameter int AW       = 31,
	parameter int TRFC_CYC = `DDRG_TRFC_CYC
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// Link
	ddrg_link_if.host               link,
	// Requests
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire logic               req_write,
	input  wire logic [AW-1:0]      req_addr,
	input  wire logic [8*ORG-1:0]   req_wdata,
	// Read answers
	output logic                    rsp_valid,
	output logic [8*ORG-1:0]        rsp_rdata,
	// Control
	input  wire logic [4:0]         cfg_cl,
	input  wire logic               temp_hot,
	input  wire logic               mps_exit,
	input  wire logic               gd_enter,
	output logic                    hot_sr_sel
);
	import ddrg_pkg::*;

	localparam int BGW = (ORG == 16) ? `DDRG_BG_W_X16 : `DDRG_BG_W_WIDE;
	localparam int RW  = (ORG == 4) ? `DDRG_ROW_W_X4 : `DDRG_ROW_W_X8;
	localparam int DW  = 2 * ORG;

	////////////////////////////////////////////////////////////////
	// Address split
	logic [9:0]  a_col;
	logic [1:0]  a_ba;
	logic [1:0]  a_bg;
	logic [16:0] a_row;

	// [R17] flat address split
	always_comb begin
		a_col = req_addr[`DDRG_COL_W-1:0];
		a_ba  = req_addr[`DDRG_COL_W +: `DDRG_BA_W];
		a_bg  = '0;
		a_row = '0;
		// [R1] [R2] group bits
		a_bg[BGW-1:0] = req_addr[`DDRG_COL_W+`DDRG_BA_W +: BGW];
		// [R3] [R4] row above column
		a_row[RW-1:0] = req_addr[`DDRG_COL_W+`DDRG_BA_W+BGW +: RW];
	end

	////////////////////////////////////////////////////////////////
	// Refresh timing and side requests
	logic        hot_s1_r;
	logic        hot_s2_r;
	logic        hot_sr_r;
	logic [11:0] ref_tmr_r;
	logic [11:0] ref_tmr_nxt;
	logic [3:0]  ref_pend_r;
	logic [3:0]  ref_pend_nxt;
	logic        nop_pend_r;
	logic        nop_pend_nxt;
	logic        take_ref;
	logic        take_nop;
	logic        tick;

	always_comb begin
		tick = (ref_tmr_r == 12'h000);
		// [R8] [R9] [R16] interval per temperature
		if (tick) begin
			ref_tmr_nxt = hot_s2_r ? 12'(`DDRG_TREFI_HOT_CYC - 1) : 12'(`DDRG_TREFI_CYC - 1);
		end else begin
			ref_tmr_nxt = ref_tmr_r - 12'h001;
		end
		ref_pend_nxt = ref_pend_r;
		if (tick && !take_ref && ref_pend_r != `DDRG_REF_PEND_MAX) begin
			ref_pend_nxt = ref_pend_r + 4'h1;
		end else if (!tick && take_ref) begin
			ref_pend_nxt = ref_pend_r - 4'h1;
		end
		nop_pend_nxt = (mps_exit || gd_enter) ? 1'b1 : (take_nop ? 1'b0 : nop_pend_r);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hot_s1_r   <= 1'b0;
			hot_s2_r   <= 1'b0;
			hot_sr_r   <= 1'b0;
			ref_tmr_r  <= 12'(`DDRG_TREFI_CYC - 1);
			ref_pend_r <= 4'h0;
			nop_pend_r <= 1'b0;
		end else if (ce) begin
			hot_s1_r   <= temp_hot;
			hot_s2_r   <= hot_s1_r;
			// [R10] hot self refresh option
			hot_sr_r   <= hot_s2_r;
			ref_tmr_r  <= ref_tmr_nxt;
			ref_pend_r <= ref_pend_nxt;
			nop_pend_r <= nop_pend_nxt;
		end
	end

	assign hot_sr_sel = hot_sr_r;

	////////////////////////////////////////////////////////////////
	// Command sequencer
	ddrg_hst_t        st_r, st_nxt;
	logic [7:0]       cnt_r, cnt_nxt;
	logic             cs_r, cs_nxt;
	logic [3:0]       cmd_r, cmd_nxt;
	logic [1:0]       bg_r, bg_nxt;
	logic [1:0]       ba_r, ba_nxt;
	logic [16:0]      addr_r, addr_nxt;
	logic [9:0]       col_r, col_nxt;
	logic             wr_r, wr_nxt;
	logic [8*ORG-1:0] wdata_r, wdata_nxt;
	logic [8*ORG-1:0] rdata_r, rdata_nxt;
	logic [1:0]       beat_r, beat_nxt;
	logic [DW-1:0]    dqo_r, dqo_nxt;
	logic             dqoe_r, dqoe_nxt;
	logic             rsp_r, rsp_nxt;
	logic [7:0]       cl_m2;

	assign req_ready = (st_r == DDRG_H_IDLE) && !nop_pend_r && (ref_pend_r == 4'h0);
	assign take_ref  = (st_r == DDRG_H_IDLE) && !nop_pend_r && (ref_pend_r != 4'h0);
	assign take_nop  = (st_r == DDRG_H_IDLE) && nop_pend_r;
	// [R11] [R12] [R15] one latency for all three waits
	assign cl_m2     = 8'(cfg_cl) - 8'h02;

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		// [R13] idle slots deselect
		cs_nxt    = 1'b1;
		cmd_nxt   = `DDRG_CMD_NOP;
		bg_nxt    = bg_r;
		ba_nxt    = ba_r;
		addr_nxt  = addr_r;
		col_nxt   = col_r;
		wr_nxt    = wr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		beat_nxt  = beat_r;
		dqo_nxt   = dqo_r;
		dqoe_nxt  = 1'b0;
		rsp_nxt   = 1'b0;
		unique case (st_r)
			DDRG_H_IDLE: begin
				if (take_nop) begin
					// [R13] NOP only for power exit or gear-down
					st_nxt  = DDRG_H_NOP;
					cs_nxt  = 1'b0;
				end else if (take_ref) begin
					st_nxt  = DDRG_H_REF;
					cs_nxt  = 1'b0;
					cmd_nxt = `DDRG_CMD_REF;
					cnt_nxt = 8'(TRFC_CYC - 1);
				end else if (req_valid) begin
					// [R14] only defined command order
					st_nxt    = DDRG_H_ACT;
					cs_nxt    = 1'b0;
					cmd_nxt   = `DDRG_CMD_ACT;
					bg_nxt    = a_bg;
					ba_nxt    = a_ba;
					addr_nxt  = a_row;
					col_nxt   = a_col;
					wr_nxt    = req_write;
					wdata_nxt = req_wdata;
				end
			end
			DDRG_H_NOP: st_nxt = DDRG_H_IDLE;
			DDRG_H_REF, DDRG_H_RP: begin
				if (cnt_r == 8'h00) begin
					st_nxt = DDRG_H_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			DDRG_H_ACT: begin
				st_nxt  = DDRG_H_RCD;
				cnt_nxt = cl_m2;
			end
			DDRG_H_RCD: begin
				if (cnt_r == 8'h00) begin
					st_nxt   = DDRG_H_COL;
					cs_nxt   = 1'b0;
					cmd_nxt  = wr_r ? `DDRG_CMD_WR : `DDRG_CMD_RD;
					addr_nxt = {7'h00, col_r};
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			DDRG_H_COL: begin
				st_nxt  = DDRG_H_LAT;
				cnt_nxt = cl_m2;
			end
			DDRG_H_LAT: begin
				if (cnt_r == 8'h00) begin
					st_nxt   = DDRG_H_BURST;
					beat_nxt = 2'h0;
					dqoe_nxt = wr_r;
					dqo_nxt  = wdata_r[DW-1:0];
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			DDRG_H_BURST: begin
				// [R6] [R7] two words per clock, four clocks
				if (!wr_r) begin
					rdata_nxt[int'(beat_r)*DW +: DW] = link.dq;
				end
				beat_nxt = beat_r + 2'h1;
				if (beat_r == 2'h3) begin
					rsp_nxt  = !wr_r;
					st_nxt   = DDRG_H_PRE;
					cs_nxt   = 1'b0;
					cmd_nxt  = `DDRG_CMD_PRE;
					addr_nxt = '0;
				end else begin
					dqoe_nxt = wr_r;
					dqo_nxt  = wdata_r[(int'(beat_r)+1)*DW +: DW];
				end
			end
			DDRG_H_PRE: begin
				st_nxt  = DDRG_H_RP;
				cnt_nxt = cl_m2;
			end
			default: st_nxt = DDRG_H_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r    <= DDRG_H_IDLE;
			cnt_r   <= 8'h00;
			cs_r    <= 1'b1;
			cmd_r   <= `DDRG_CMD_NOP;
			bg_r    <= 2'h0;
			ba_r    <= 2'h0;
			addr_r  <= 17'h0_0000;
			col_r   <= 10'h000;
			wr_r    <= 1'b0;
			wdata_r <= '0;
			rdata_r <= '0;
			beat_r  <= 2'h0;
			dqo_r   <= '0;
			dqoe_r  <= 1'b0;
			rsp_r   <= 1'b0;
		end else if (ce) begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			cs_r    <= cs_nxt;
			cmd_r   <= cmd_nxt;
			bg_r    <= bg_nxt;
			ba_r    <= ba_nxt;
			addr_r  <= addr_nxt;
			col_r   <= col_nxt;
			wr_r    <= wr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			beat_r  <= beat_nxt;
			dqo_r   <= dqo_nxt;
			dqoe_r  <= dqoe_nxt;
			rsp_r   <= rsp_nxt;
		end
	end

	assign link.cs_n    = cs_r;
	assign link.act_n   = cmd_r[3];
	assign link.ras_n   = cmd_r[2];
	assign link.cas_n   = cmd_r[1];
	assign link.we_n    = cmd_r[0];
	assign link.bg      = bg_r;
	assign link.ba      = ba_r;
	assign link.addr    = addr_r;
	assign link.h_dq_o  = dqo_r;
	assign link.h_dq_oe = dqoe_r;
	assign rsp_valid    = rsp_r;
	assign rsp_rdata    = rdata_r;

endmodule

`default_nettype wire

// ---- ddrg_dev.sv ----
`include "ddrg_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ddrg_dev #(
	parameter int ORG       = 8,
	parameter int MCOL      = 5,
	parameter bit X4_PAGE1K = 1'b0
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// Link
	ddrg_link_if.dev                link,
	// Configuration
	input  wire ddrg_pkg::ddrg_rate_t cfg_rate,
	input  wire logic [4:0]         cfg_cl,
	// Status
	output logic                    cl_ok,
	output logic                    err_undef,
	output logic                    ref_seen,
	output logic [11:0]             page_bytes,
	output logic [4:0]              bank_count
);
	import ddrg_pkg::*;

	localparam int RW = (ORG == 4) ? `DDRG_ROW_W_X4 : `DDRG_ROW_W_X8;
	localparam int DW = 2 * ORG;
	localparam int MW = 4 + MCOL;
	localparam int NB = `DDRG_BANKS_WIDE;

	// [R5] page size per bank
	localparam int PAGE = (ORG == 4 && X4_PAGE1K) ? 1024 : ((1 << `DDRG_COL_W) * ORG / 8);

	// [R1] [R2] visible bank count
	assign bank_count = (ORG == 16) ? 5'(`DDRG_BANKS_X16) : 5'(`DDRG_BANKS_WIDE);
	assign page_bytes = 12'(PAGE);

	////////////////////////////////////////////////////////////////
	// Latency legality
	function automatic logic cl_legal(input ddrg_rate_t r, input logic [4:0] c);
		unique case (r)
			DDRG_R1600: cl_legal = (c == 5'h0B);
			DDRG_R1866: cl_legal = (c == 5'h0D);
			DDRG_R2133: cl_legal = (c == 5'h0F) || (c == 5'h10);
			DDRG_R2400: cl_legal = (c == 5'h10) || (c == 5'h11);
			DDRG_R2666: cl_legal = (c == 5'h12) || (c == 5'h13);
			DDRG_R2933: cl_legal = (c == 5'h14) || (c == 5'h15);
			DDRG_R3200: cl_legal = (c == 5'h16);
			default:    cl_legal = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// Bank state and command decode
	ddrg_dst_t        st_r, st_nxt;
	logic [NB-1:0]    open_r, open_nxt;
	logic [16:0]      row_r [NB];
	logic [16:0]      row_nxt [NB];
	logic [7:0]       cnt_r, cnt_nxt;
	logic             wr_r, wr_nxt;
	logic [MW-4:0]    base_r, base_nxt;
	logic [1:0]       beat_r, beat_nxt;
	logic [DW-1:0]    dqo_r, dqo_nxt;
	logic             dqoe_r, dqoe_nxt;
	logic             err_r, err_nxt;
	logic             ref_r, ref_nxt;
	logic             clok_r;
	logic [3:0]       cmd;
	logic [3:0]       bidx;
	logic [16:0]      row_in;
	logic [ORG-1:0]   mem_r [1 << MW];
	logic [MW-1:0]    widx;

	always_comb begin
		cmd    = {link.act_n, link.ras_n, link.cas_n, link.we_n};
		// [R1] [R2] group and bank select
		bidx   = (ORG == 16) ? {1'b0, link.bg[0], link.ba} : {link.bg, link.ba};
		// [R3] row width per organisation
		row_in = '0;
		row_in[RW-1:0] = link.addr[RW-1:0];
	end

	always_comb begin
		st_nxt   = st_r;
		open_nxt = open_r;
		row_nxt  = row_r;
		cnt_nxt  = cnt_r;
		wr_nxt   = wr_r;
		base_nxt = base_r;
		beat_nxt = beat_r;
		dqo_nxt  = dqo_r;
		dqoe_nxt = 1'b0;
		err_nxt  = 1'b0;
		ref_nxt  = 1'b0;
		if (!link.cs_n) begin
			case (cmd)
				`DDRG_CMD_NOP: err_nxt = 1'b0;
				`DDRG_CMD_ACT: begin
					err_nxt        = open_r[bidx];
					open_nxt[bidx] = 1'b1;
					row_nxt[bidx]  = row_in;
				end
				`DDRG_CMD_RD, `DDRG_CMD_WR: begin
					err_nxt = !open_r[bidx] || (st_r != DDRG_D_IDLE);
					if (st_r == DDRG_D_IDLE) begin
						st_nxt   = DDRG_D_LAT;
						// [R11] column latency in clocks
						cnt_nxt  = 8'(cfg_cl) - 8'h02;
						wr_nxt   = (cmd == `DDRG_CMD_WR);
						// [R4] column on low ten bits
						base_nxt = {bidx, link.addr[MCOL-1:3]};
					end
				end
				`DDRG_CMD_PRE: begin
					if (link.addr[`DDRG_AP_BIT]) begin
						open_nxt = '0;
					end else begin
						open_nxt[bidx] = 1'b0;
					end
				end
				`DDRG_CMD_REF: begin
					err_nxt = |open_r;
					ref_nxt = 1'b1;
				end
				// [R14] undefined codes flagged
				default: err_nxt = 1'b1;
			endcase
		end
		unique case (st_r)
			DDRG_D_IDLE: beat_nxt = 2'h0;
			DDRG_D_LAT: begin
				if (cnt_r == 8'h00) begin
					st_nxt   = DDRG_D_BURST;
					beat_nxt = 2'h0;
					dqoe_nxt = !wr_r;
					dqo_nxt  = {mem_r[{base_r, 3'h1}], mem_r[{base_r, 3'h0}]};
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			DDRG_D_BURST: begin
				// [R6] [R7] pair of words each clock
				beat_nxt = beat_r + 2'h1;
				if (beat_r == 2'h3) begin
					st_nxt = DDRG_D_IDLE;
				end else begin
					dqoe_nxt = !wr_r;
					dqo_nxt  = {mem_r[{base_r, beat_nxt, 1'b1}], mem_r[{base_r, beat_nxt, 1'b0}]};
				end
			end
			default: st_nxt = DDRG_D_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r   <= DDRG_D_IDLE;
			open_r <= '0;
			row_r  <= '{default: 17'h0_0000};
			cnt_r  <= 8'h00;
			wr_r   <= 1'b0;
			base_r <= '0;
			beat_r <= 2'h0;
			dqo_r  <= '0;
			dqoe_r <= 1'b0;
			err_r  <= 1'b0;
			ref_r  <= 1'b0;
			clok_r <= 1'b0;
		end else if (ce) begin
			st_r   <= st_nxt;
			open_r <= open_nxt;
			row_r  <= row_nxt;
			cnt_r  <= cnt_nxt;
			wr_r   <= wr_nxt;
			base_r <= base_nxt;
			beat_r <= beat_nxt;
			dqo_r  <= dqo_nxt;
			dqoe_r <= dqoe_nxt;
			err_r  <= err_nxt;
			ref_r  <= ref_nxt;
			// [R12] latency valid for rate
			clok_r <= cl_legal(cfg_rate, cfg_cl);
		end
	end

	////////////////////////////////////////////////////////////////
	// Word storage
	assign widx = {base_r, beat_r, 1'b0};

	for (genvar i = 0; i < (1 << MW); i++) begin : g_mem
		always_ff @(posedge clock) begin
			// [R7] both half-clock words stored
			if (ce && st_r == DDRG_D_BURST && wr_r && widx[MW-1:1] == MW'(i) >> 1) begin
				mem_r[i] <= link.dq[(i % 2)*ORG +: ORG];
			end
		end
	end

	assign link.d_dq_o  = dqo_r;
	assign link.d_dq_oe = dqoe_r;
	assign cl_ok        = clok_r;
	assign err_undef    = err_r;
	assign ref_seen     = ref_r;

endmodule

`default_nettype wire

// ---- ddrg_link_monitor.sv ----
`include "ddrg_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ddrg_link_monitor #(
	parameter int CL = 11
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Command lines
	input  wire logic        cs_n,
	input  wire logic        act_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  bg,
	input  wire logic [1:0]  ba,
	input  wire logic [16:0] addr,
	// Data enables
	input  wire logic        h_dq_oe,
	input  wire logic        d_dq_oe
);
	logic [3:0]  cmd;
	logic        is_act;
	logic        is_col;
	logic        is_pre;
	logic        is_ref;
	logic [11:0] since_pre_r;
	logic [11:0] since_pre_nxt;
	logic [11:0] since_ref_r;
	logic [11:0] since_ref_nxt;

	assign cmd = {act_n, ras_n, cas_n, we_n};
	assign is_act = !cs_n && cmd == `DDRG_CMD_ACT;
	assign is_col = !cs_n && (cmd == `DDRG_CMD_RD || cmd == `DDRG_CMD_WR);
	assign is_pre = !cs_n && cmd == `DDRG_CMD_PRE;
	assign is_ref = !cs_n && cmd == `DDRG_CMD_REF;

	////////////////////////////////////////////////////////////////
	// Cycles since last precharge and refresh
	always_comb begin
		since_pre_nxt = (since_pre_r == 12'hFFF) ? since_pre_r : since_pre_r + 12'h001;
		since_ref_nxt = (since_ref_r == 12'hFFF) ? since_ref_r : since_ref_r + 12'h001;
		if (is_pre) begin
			since_pre_nxt = 12'h001;
		end
		if (is_ref) begin
			since_ref_nxt = 12'h001;
		end
		if (!rst_n) begin
			since_pre_nxt = 12'hFFF;
			since_ref_nxt = 12'h000;
		end
	end

	always_ff @(posedge clock) begin
		since_pre_r <= since_pre_nxt;
		since_ref_r <= since_ref_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_wr_burst;
		h_dq_oe [*4] ##1 !h_dq_oe;
	endsequence
	sequence s_rd_burst;
		d_dq_oe [*4] ##1 (!d_dq_oe && is_pre);
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n ##1 !rst_n |-> cs_n && !h_dq_oe && !d_dq_oe)
		else $error("link not quiet in reset");
	a_act_to_col: assert property (is_act |-> ##CL
		(is_col && bg == $past(bg, CL) && ba == $past(ba, CL)))
		else $error("column command not at row delay");
	a_wr_burst: assert property (is_col && cmd == `DDRG_CMD_WR |-> ##CL (!d_dq_oe) [*4])
		else $error("device drives data during write burst");
	a_wr_data: assert property (is_col && cmd == `DDRG_CMD_WR |-> ##CL s_wr_burst)
		else $error("write burst shape wrong");
	a_rd_data: assert property (is_col && cmd == `DDRG_CMD_RD |-> ##CL s_rd_burst)
		else $error("read burst shape wrong");
	a_pre_to_act: assert property ((is_act || is_ref) |-> since_pre_r >= CL)
		else $error("activate too soon after precharge");
	a_dq_one_owner: assert property (!(h_dq_oe && d_dq_oe))
		else $error("both ends drive data");
	a_ref_quiet: assert property (is_ref |=> cs_n [*4])
		else $error("command inside refresh recovery");
	a_ref_interval: assert property (since_ref_r <= 12'h7D0)
		else $error("refresh interval too long");
	a_row_width: assert property (is_act |-> addr[16] == 1'b0)
		else $error("row wider than sixteen bits");
	a_col_low: assert property (is_col |-> addr[16:10] == 7'h00)
		else $error("column outside low ten bits");
endmodule

`default_nettype wire

// ---- testbench.sv ----
`include "ddrg_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import ddrg_pkg::*;
	localparam int CL = 11;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        req_valid = 1'b0;
	logic        req_ready;
	logic        req_write = 1'b0;
	logic [30:0] req_addr = '0;
	logic [63:0] req_wdata = '0;
	logic        rsp_valid;
	logic [63:0] rsp_rdata;
	logic [4:0]  cfg_cl = 5'h0B;
	logic        temp_hot = 1'b0;
	logic        mps_exit = 1'b0;
	logic        gd_enter = 1'b0;
	logic        hot_sr_sel;
	ddrg_rate_t  cfg_rate = DDRG_R1600;
	logic        cl_ok, err_undef, ref_seen, err16;
	logic [11:0] page_bytes, page16;
	logic [4:0]  bank_count, bank16;
	logic [3:0]  lcmd;
	logic [20:0] act_f;
	logic [9:0]  col_f;
	logic [63:0] wbeats, rd, dat [16];
	logic [30:0] adr [16];
	int          seed = 21;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, n_nop = 0, n_ref = 0;
	int          n_rseen = 0, n_err = 0, n_err16 = 0, ref_at = 0, ref_gap = 0;

	ddrg_link_if #(.ORG(8)) lnk ();
	ddrg_link_if #(.ORG(16)) lnk16 ();
	ddrg_host #(.ORG(8), .AW(31), .TRFC_CYC(4)) ddrg_host_i (.clock(clock), .rst_n(rst_n),
		.ce(ce), .link(lnk), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cfg_cl(cfg_cl), .temp_hot(temp_hot),
		.mps_exit(mps_exit), .gd_enter(gd_enter), .hot_sr_sel(hot_sr_sel));
	ddrg_dev #(.ORG(8)) ddrg_dev_i (.clock(clock), .rst_n(rst_n), .ce(ce), .link(lnk),
		.cfg_rate(cfg_rate), .cfg_cl(cfg_cl), .cl_ok(cl_ok), .err_undef(err_undef),
		.ref_seen(ref_seen), .page_bytes(page_bytes), .bank_count(bank_count));
	ddrg_dev #(.ORG(16)) ddrg_dev_x16_i (.clock(clock), .rst_n(rst_n), .ce(ce), .link(lnk16),
		.cfg_rate(cfg_rate), .cfg_cl(cfg_cl), .cl_ok(), .err_undef(err16),
		.ref_seen(), .page_bytes(page16), .bank_count(bank16));
	ddrg_link_monitor #(.CL(CL)) ddrg_link_monitor_i (.clock(clock), .rst_n(rst_n),
		.cs_n(lnk.cs_n), .act_n(lnk.act_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
		.we_n(lnk.we_n), .bg(lnk.bg), .ba(lnk.ba), .addr(lnk.addr),
		.h_dq_oe(lnk.h_dq_oe), .d_dq_oe(lnk.d_dq_oe));

	always #2 clock = ~clock;
	assign lcmd = {lnk.act_n, lnk.ras_n, lnk.cas_n, lnk.we_n};

	////////////////////////////////////////////////////////////////
	// Wire watcher and timeout
	always @(posedge clock) begin
		cyc++;
		if (rst_n && !lnk.cs_n && lcmd == `DDRG_CMD_ACT) act_f = {lnk.bg, lnk.ba, lnk.addr};
		if (rst_n && !lnk.cs_n && lcmd inside {`DDRG_CMD_RD, `DDRG_CMD_WR}) col_f = lnk.addr[9:0];
		if (rst_n && !lnk.cs_n && lcmd == `DDRG_CMD_NOP) n_nop++;
		if (rst_n && !lnk.cs_n && lcmd == `DDRG_CMD_REF) begin
			ref_gap = cyc - ref_at;
			ref_at = cyc;
			n_ref++;
		end
		if (lnk.h_dq_oe) wbeats = {lnk.dq, wbeats[63:16]};
		if (rst_n && err_undef) n_err++;
		if (rst_n && err16) n_err16++;
		if (rst_n && ref_seen) n_rseen++;
		if (cyc > 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [20:0] exp_act(input logic [30:0] a);
		return {a[13:12], a[11:10], 1'b0, a[29:14]};
	endfunction

	function automatic logic exp_clok(input int r, input int c);
		case (r)
			0: return c == 11;
			1: return c == 13;
			2: return c == 15 || c == 16;
			3: return c == 16 || c == 17;
			4: return c == 18 || c == 19;
			5: return c == 20 || c == 21;
			default: return c == 22;
		endcase
	endfunction

	// One host access, waits until idle again
	task automatic access(input logic wr, input logic [30:0] a, input logic [63:0] d);
		int k;
		@(negedge clock);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		for (k = 0; k < 3000 && req_ready !== 1'b1; k++) @(negedge clock);
		@(negedge clock);
		req_valid = 1'b0;
		for (k = 0; k < 200 && req_ready !== 1'b1; k++) begin
			if (rsp_valid === 1'b1) rd = rsp_rdata;
			@(negedge clock);
		end
		check("act_fields", act_f, exp_act(a));
		check("col_field", col_f, a[9:0]);
		if (wr) check("write_beats", wbeats, d);
	endtask

	task automatic cmd16(input logic [3:0] code, input logic [1:0] g, input logic [16:0] a);
		@(negedge clock);
		lnk16.bg = g;
		lnk16.addr = a;
		lnk16.cs_n = 1'b0;
		{lnk16.act_n, lnk16.ras_n, lnk16.cas_n, lnk16.we_n} = code;
		@(negedge clock);
		lnk16.cs_n = 1'b1;
		{lnk16.act_n, lnk16.ras_n, lnk16.cas_n, lnk16.we_n} = `DDRG_CMD_NOP;
		repeat (3) @(negedge clock);
	endtask

	task automatic wait_refs(input int n);
		int k0;
		k0 = n_ref + n;
		while (n_ref < k0) @(negedge clock);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{lnk16.cs_n, lnk16.act_n, lnk16.ras_n, lnk16.cas_n, lnk16.we_n} = 5'h1F;
		{lnk16.bg, lnk16.ba, lnk16.addr, lnk16.h_dq_o, lnk16.h_dq_oe} = '0;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		check("cs_idle", lnk.cs_n, 1'b1);
		check("bank_count", bank_count, 5'h10);
		check("page_bytes", page_bytes, 12'h400);
		check("bank_count16", bank16, 5'h08);
		check("page_bytes16", page16, 12'h800);
		$display("reset test done");
		for (int b = 0; b < 16; b++) begin
			adr[b] = 31'($random(seed));
			adr[b][30] = 1'b0;
			adr[b][13:10] = b[3:0];
			if (b == 0) adr[b][29:14] = 16'h0000;
			if (b == 15) adr[b] = 31'h3FFF_FFFF;
			dat[b] = {$random(seed), $random(seed)};
			access(1'b1, adr[b], dat[b]);
		end
		for (int b = 0; b < 16; b++) begin
			access(1'b0, adr[b], '0);
			check("read_data", rd, dat[b]);
		end
		$display("bank test done");
		check("nop_none", n_nop, 0);
		@(negedge clock) mps_exit = 1'b1;
		@(negedge clock) mps_exit = 1'b0;
		repeat (80) @(negedge clock);
		gd_enter = 1'b1;
		@(negedge clock) gd_enter = 1'b0;
		repeat (80) @(negedge clock);
		check("nop_count", n_nop, 2);
		$display("nop test done");
		for (int r = 0; r < 7; r++) begin
			for (int c = 10; c < 24; c++) begin
				@(negedge clock);
				cfg_rate = ddrg_rate_t'(r);
				cfg_cl = c[4:0];
				@(negedge clock);
				check("cl_ok", cl_ok, exp_clok(r, c));
			end
		end
		cfg_cl = 5'h0B;
		cfg_rate = DDRG_R1600;
		$display("latency test done");
		wait_refs(2);
		check("ref_gap_cool", ref_gap, 1953);
		@(negedge clock);
		ce = 1'b0;
		temp_hot = 1'b1;
		repeat (5) @(negedge clock);
		check("hot_sel_frozen", hot_sr_sel, 1'b0);
		ce = 1'b1;
		repeat (2) @(negedge clock);
		check("hot_sel_early", hot_sr_sel, 1'b0);
		@(negedge clock);
		check("hot_sel", hot_sr_sel, 1'b1);
		wait_refs(3);
		check("ref_gap_hot", ref_gap, 976);
		repeat (3) @(negedge clock);
		check("ref_seen", n_rseen, n_ref);
		check("err_none", n_err, 0);
		$display("refresh test done");
		cmd16(`DDRG_CMD_RD, 2'h0, 17'h0_0000);
		check("err_rd_closed", n_err16, 1);
		cmd16(`DDRG_CMD_REF, 2'h0, 17'h0_0000);
		check("err_ref_legal", n_err16, 1);
		cmd16(`DDRG_CMD_ACT, 2'h0, 17'h0_0000);
		cmd16(`DDRG_CMD_ACT, 2'h1, 17'h0_0000);
		check("err_act_other", n_err16, 1);
		cmd16(`DDRG_CMD_ACT, 2'h2, 17'h0_0000);
		check("err_act_open", n_err16, 2);
		cmd16(`DDRG_CMD_PRE, 2'h0, 17'h0_0400);
		cmd16(`DDRG_CMD_REF, 2'h0, 17'h0_0000);
		check("err_pre_all", n_err16, 2);
		$display("fault test done");
		test_done();
	end
endmodule

`default_nettype wire
